// ---- rtl/meb_consts.vh ----
`ifndef MEB_CONSTS_VH
`define MEB_CONSTS_VH

// Machine cycle rhythm.
`define MEB_CLKS_PER_CYCLE      4
`define MEB_PHASE_W             2
`define MEB_PHASE_ADDR          2'h0
`define MEB_PHASE_LAST          2'h3
`define MEB_SLOW_TIMER_CLKS     12
`define MEB_SLOW_TIMER_CYCLES   (`MEB_SLOW_TIMER_CLKS / `MEB_CLKS_PER_CYCLE)
`define MEB_SLOW_CNT_W          2
`define MEB_TIMER_COUNT         3

// Fastest external data move, in machine cycles.
`define MEB_DATA_MOVE_CYCLES    2

// Request kinds.
`define MEB_KIND_W              2
`define MEB_KIND_FETCH          2'h0
`define MEB_KIND_DATA_READ      2'h1
`define MEB_KIND_DATA_WRITE     2'h2

// Bus cycle states.
`define MEB_ST_W                2
`define MEB_ST_IDLE             2'h0
`define MEB_ST_FETCH            2'h1
`define MEB_ST_DATA_ADDR        2'h2
`define MEB_ST_DATA_STROBE      2'h3

// Reset level of the port pins and stages of the strap-pin filter.
`define MEB_PORT_RESET          8'hFF
`define MEB_SYNC_STAGES         3

`endif

// ---- rtl/meb_cycle_timer.v ----
`timescale 1ns/1ns
`include "meb_consts.vh"

module meb_cycle_timer #(
  parameter TIMERS = `MEB_TIMER_COUNT
) (
  input  wire              core_clk,
  input  wire              rst_n,
  input  wire [TIMERS-1:0] timer_fast_sel,
  output reg  [1:0]        phase,
  output wire              cycle_end,
  output reg  [TIMERS-1:0] timer_tick
);

  reg  [`MEB_SLOW_CNT_W-1:0] slow_cnt;
  wire                       slow_hit;
  wire [1:0]                 next_phase;
  genvar                     i;

  // Four clocks make a machine cycle and no cycle is ever skipped.
  assign next_phase = phase + 2'h1; // R10
  assign cycle_end  = (phase == `MEB_PHASE_LAST); // R10
  assign slow_hit   = cycle_end &&
                      (slow_cnt == (`MEB_SLOW_TIMER_CYCLES - 1));

  always @(posedge core_clk) begin
    if (!rst_n) begin
      phase    <= 2'h0;
      slow_cnt <= 2'h0;
    end else begin
      phase <= next_phase;
      if (slow_hit)
        slow_cnt <= 2'h0;
      else if (cycle_end)
        slow_cnt <= slow_cnt + 2'h1;
    end
  end

  // Each timer picks its own rate: once per machine cycle, or once per three.
  generate
    for (i = 0; i < TIMERS; i = i + 1) begin : g_tick
      always @(posedge core_clk) begin
        if (!rst_n)
          timer_tick[i] <= 1'b0;
        else
          timer_tick[i] <= timer_fast_sel[i] ? cycle_end : slow_hit; // R14
      end
    end
  endgenerate

endmodule

// ---- rtl/meb_bus.v ----
// Function
// R1: Program memory is enabled by the strobe program_store_strobe_n driven low during fetches.
// R2: program_store_strobe_n stays high through every data access and throughout reset.
// R3: The address latch strobe is forced high while reset is held.
// R4: The outside latch captures the low address byte from the port with the latch strobe.
// R5: While the latch strobe is high the port carries the low address byte. In idle cycles the code releases the port instead.
// R6: After the latch strobe falls the port serves as a data bus until the cycle ends.
// R7: The data bus reads code and reads or writes external data memory and peripherals.
// R8: The port has no software latch and is driven only by bus cycles.
// R9: The port stands high while reset is held.
// R10: Every machine cycle is four clocks with no dummy cycles.
// R11: One latch strobe pulse is given in every machine cycle.
// R12: An external data move takes at least two machine cycles, eight clocks.
// R13: One machine cycle is spent per instruction byte, so instructions take one to five cycles.
// R14: Timers advance every twelve clocks by default, each selectable to every four.
// R15: Instruction effects match the classic instruction set; only timing differs.
// R16: External parts drive read data before the read strobe ends and release afterwards.
`timescale 1ns/1ns
`include "meb_consts.vh"

module meb_bus #(
  parameter TIMERS = `MEB_TIMER_COUNT
) (
  input  wire                   core_clk,
  input  wire                   rst_n,
  input  wire                   req_valid,
  output wire                   req_ready,
  input  wire [`MEB_KIND_W-1:0] req_kind,
  input  wire [7:0]             req_addr,
  input  wire [7:0]             req_wdata,
  output reg                    resp_valid,
  output reg  [7:0]             resp_rdata,
  output reg                    access_fault,
  input  wire [TIMERS-1:0]      timer_fast_sel,
  output wire [TIMERS-1:0]      timer_tick,
  input  wire                   external_access_n,
  output reg                    addr_latch_strobe,
  output reg                    program_store_strobe_n,
  output reg                    data_read_strobe_n,
  output reg                    data_write_strobe_n,
  input  wire [7:0]             muxed_addr_data_in,
  output reg  [7:0]             muxed_addr_data_out,
  output reg                    muxed_addr_data_oe
);

  reg  [`MEB_ST_W-1:0]   state;
  reg  [`MEB_KIND_W-1:0] kind;
  reg  [7:0]             addr;
  reg  [7:0]             wdata;
  reg  [`MEB_ST_W-1:0]   next_state;
  reg  [`MEB_KIND_W-1:0] next_kind;
  reg  [7:0]             next_addr;
  reg  [7:0]             next_wdata;
  reg                    next_ale;
  reg                    next_program_store_strobe_n_n;
  reg                    next_rd_n;
  reg                    next_wr_n;
  reg  [7:0]             next_port;
  reg                    next_oe;
  reg  [`MEB_SYNC_STAGES-1:0] ea_sync;
  reg                    ext_access_ok;
  wire [1:0]             phase;
  wire [1:0]             next_phase;
  wire                   cycle_end;
  wire                   accept;
  wire                   sample;

  // Kind decoding is needed by both the next-state and the pin logic, so it
  // lives in functions to keep the two views from drifting apart.
  // A kind code of three is not a data move and is run as a fetch.

  function is_write;
    input [`MEB_KIND_W-1:0] k;
    begin
      is_write = (k == `MEB_KIND_DATA_WRITE);
    end
  endfunction

  function is_data;
    input [`MEB_KIND_W-1:0] k;
    begin
      is_data = (k == `MEB_KIND_DATA_READ) || (k == `MEB_KIND_DATA_WRITE);
    end
  endfunction

  meb_cycle_timer #(
    .TIMERS (TIMERS)
  ) u_cycle (
    .core_clk       (core_clk),
    .rst_n          (rst_n),
    .timer_fast_sel (timer_fast_sel),
    .phase          (phase),
    .cycle_end      (cycle_end),
    .timer_tick     (timer_tick)
  );

  assign next_phase = phase + 2'h1;

  // The strap pin is asynchronous, so it is filtered before use.
  // The chain starts at the inactive level, so no request is accepted until
  // the pin has been seen low on two stages in a row after reset.
  always @(posedge core_clk) begin
    if (!rst_n) begin
      ea_sync       <= 3'h7;
      ext_access_ok <= 1'b0;
    end else begin
      ea_sync <= {ea_sync[1:0], external_access_n};
      if (ea_sync[1] == ea_sync[2])
        ext_access_ok <= ~ea_sync[2];
    end
  end

  // A new request starts only on a machine cycle boundary. The second
  // cycle of a data move is never shared, so ready drops while it is due.
  assign req_ready = cycle_end && ext_access_ok &&
                     (state != `MEB_ST_DATA_ADDR); // R12
  assign accept    = req_valid && req_ready; // R13

  always @* begin
    next_state = state;
    next_kind  = kind;
    next_addr  = addr;
    next_wdata = wdata;
    if (cycle_end) begin
      if (state == `MEB_ST_DATA_ADDR) begin
        next_state = `MEB_ST_DATA_STROBE; // R12
      end else if (accept) begin
        next_kind  = req_kind;
        next_addr  = req_addr;
        next_wdata = req_wdata;
        if (is_data(req_kind))
          next_state = `MEB_ST_DATA_ADDR;
        else
          next_state = `MEB_ST_FETCH;
      end else begin
        next_state = `MEB_ST_IDLE;
      end
    end
  end

  // Pin levels for the coming clock, so that every pin is a flip-flop and
  // all of them move on the same edge as the state.
  // Write data is driven in both cycles of a write so the port never floats
  // between address and data; reads and fetches release it after the strobe.
  // The latch strobe pulses even in idle cycles, which keeps the rhythm fixed
  // for anything that counts machine cycles on the pin.
  always @* begin
    next_ale    = (next_phase == `MEB_PHASE_ADDR); // R11
    next_program_store_strobe_n_n = 1'b1; // R2
    next_rd_n   = 1'b1;
    next_wr_n   = 1'b1;
    next_port   = `MEB_PORT_RESET;
    next_oe     = 1'b0;
    if (next_phase == `MEB_PHASE_ADDR) begin
      if (next_state != `MEB_ST_IDLE) begin
        next_port = next_addr; // R5
        next_oe   = 1'b1; // R4
      end
    end else begin
      if (next_state == `MEB_ST_FETCH)
        next_program_store_strobe_n_n = 1'b0; // R1
      if (next_state == `MEB_ST_DATA_STROBE) begin
        next_rd_n = is_write(next_kind); // R7
        next_wr_n = ~is_write(next_kind); // R7
      end
      if (is_data(next_state == `MEB_ST_IDLE ? `MEB_KIND_FETCH : next_kind) &&
          is_write(next_kind) && (next_state != `MEB_ST_FETCH)) begin
        next_port = next_wdata; // R6
        next_oe   = 1'b1; // R6
      end
    end
  end

  // No software write path exists; the port follows bus cycles only.
  // In reset the port is driven high rather than released, so that the pins
  // show a defined level even without pull-ups on the board.
  always @(posedge core_clk) begin
    if (!rst_n) begin
      state                  <= `MEB_ST_IDLE;
      kind                   <= `MEB_KIND_FETCH;
      addr                   <= 8'h00;
      wdata                  <= 8'h00;
      addr_latch_strobe      <= 1'b1; // R3
      program_store_strobe_n <= 1'b1; // R2
      data_read_strobe_n     <= 1'b1;
      data_write_strobe_n    <= 1'b1;
      muxed_addr_data_out    <= `MEB_PORT_RESET; // R9
      muxed_addr_data_oe     <= 1'b1; // R9
    end else begin
      state                  <= next_state;
      kind                   <= next_kind;
      addr                   <= next_addr;
      wdata                  <= next_wdata;
      addr_latch_strobe      <= next_ale;
      program_store_strobe_n <= next_program_store_strobe_n_n;
      data_read_strobe_n     <= next_rd_n;
      data_write_strobe_n    <= next_wr_n;
      muxed_addr_data_out    <= next_port; // R8
      muxed_addr_data_oe     <= next_oe;
    end
  end

  // Read data is taken on the edge that ends the strobe. The port is timed
  // by our own strobes, so it is sampled directly rather than synchronised.
  assign sample = (phase == `MEB_PHASE_LAST) &&
                  ((state == `MEB_ST_FETCH) || (state == `MEB_ST_DATA_STROBE)); // R16

  always @(posedge core_clk) begin
    if (!rst_n) begin
      resp_valid   <= 1'b0;
      resp_rdata   <= 8'h00;
      access_fault <= 1'b0;
    end else begin
      resp_valid   <= sample;
      access_fault <= cycle_end && req_valid && !ext_access_ok;
      // The byte is handed to the core exactly as read, so instruction effects
      // are left entirely to the core and only the timing is set here.
      // A write leaves the last read byte in place for the core to reuse.
      if (sample && !is_write(kind))
        resp_rdata <= muxed_addr_data_in; // R7 R15
    end
  end

endmodule

// ---- verif/meb_bus_checker.sv ----
`timescale 1ns/1ns
module meb_bus_checker (
  input wire       core_clk,
  input wire       rst_n,
  input wire       req_valid,
  input wire       req_ready,
  input wire [1:0] req_kind,
  input wire [7:0] req_addr,
  input wire       resp_valid,
  input wire       addr_latch_strobe,
  input wire       program_store_strobe_n,
  input wire       data_read_strobe_n,
  input wire       data_write_strobe_n,
  input wire [7:0] muxed_addr_data_out,
  input wire       muxed_addr_data_oe
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wire take = req_valid && req_ready;
  rst_pins_a: assert property (disable iff (1'b0) !rst_n |=> addr_latch_strobe &&
    program_store_strobe_n && muxed_addr_data_oe && muxed_addr_data_out == 8'hFF)
    else $error("pin levels wrong in reset");
  ale_period_a: assert property ($rose(addr_latch_strobe) |=>
    !addr_latch_strobe [*3] ##1 addr_latch_strobe) else $error("latch strobe period wrong");
  addr_drive_a: assert property (take |=> addr_latch_strobe && muxed_addr_data_oe &&
    muxed_addr_data_out == $past(req_addr)) else $error("address not on port");
  fetch_strobe_a: assert property ($fell(program_store_strobe_n) |->
    !program_store_strobe_n [*3] ##1 addr_latch_strobe) else $error("fetch strobe width wrong");
  fetch_bus_a: assert property (!program_store_strobe_n |-> !muxed_addr_data_oe &&
    !addr_latch_strobe) else $error("port driven during fetch");
  read_bus_a: assert property (!data_read_strobe_n |-> !muxed_addr_data_oe &&
    program_store_strobe_n) else $error("port driven during read");
  write_bus_a: assert property (!data_write_strobe_n |-> muxed_addr_data_oe &&
    program_store_strobe_n) else $error("write data not driven");
  fetch_len_a: assert property (take && req_kind == 2'h0 |-> ##5 resp_valid)
    else $error("fetch answer late");
  move_len_a: assert property (take && (req_kind[0] ^ req_kind[1]) |->
    ##2 !resp_valid [*7] ##1 resp_valid) else $error("data move length wrong");
endmodule
bind meb_bus meb_bus_checker u_chk (.*);

// ---- verif/meb_ext_mem.sv ----
`timescale 1ns/1ns
module meb_ext_mem (
  input wire       core_clk,
  input wire       ale,
  input wire       program_store_strobe_n_n,
  input wire       rd_n,
  input wire       wr_n,
  input wire       oe,
  input wire [7:0] dout,
  output reg [7:0] pin
);
  reg [7:0] lat;
  reg [7:0] last;
  reg [7:0] ram [0:255];
  // Capture at the clock keeps the latch clear of the port turning round at strobe fall.
  always @(posedge core_clk) if (ale) lat <= dout;
  always @(posedge core_clk) if (!wr_n) ram[lat] <= dout;
  always @(posedge core_clk) last <= pin;
  // A released bus shows a changing pattern, never the last value.
  always @* pin = oe ? dout : !program_store_strobe_n_n ? lat ^ 8'hA5 : !rd_n ? ram[lat] : ~last;
endmodule

// ---- verif/meb_bus_tb_top.sv ----
`timescale 1ns/1ns
module meb_bus_tb_top;
  reg        core_clk = 0, rst_n = 0, req_valid = 0, external_access_n = 0;
  reg  [1:0] req_kind = 0;
  reg  [7:0] req_addr = 0, req_wdata = 0, got;
  reg  [2:0] timer_fast_sel = 0;
  wire       req_ready, resp_valid, access_fault, addr_latch_strobe, program_store_strobe_n;
  wire       data_read_strobe_n, data_write_strobe_n, muxed_addr_data_oe;
  wire [7:0] resp_rdata, muxed_addr_data_out, muxed_addr_data_in;
  wire [2:0] timer_tick;
  integer    err_count = 0, num_checks = 0, i, n0, n1, n2, na;
  always #5 core_clk = ~core_clk;
  meb_bus DUT (.*);
  meb_ext_mem u_mem (.core_clk, .ale(addr_latch_strobe), .program_store_strobe_n_n(program_store_strobe_n),
    .rd_n(data_read_strobe_n), .wr_n(data_write_strobe_n), .oe(muxed_addr_data_oe),
    .dout(muxed_addr_data_out), .pin(muxed_addr_data_in));
  task chk(input string nm, input [7:0] e, input [7:0] g);
    num_checks++;
    if (g !== e) begin
      $display("FAIL %0s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask
  task give_verdict;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task bus(input [1:0] k, input [7:0] a, input [7:0] d);
    @(posedge core_clk);
    req_valid <= 1; req_kind <= k; req_addr <= a; req_wdata <= d;
    @(negedge core_clk);
    for (i = 0; i < 20 && req_ready !== 1'b1; i++) @(negedge core_clk);
    @(posedge core_clk);
    req_valid <= 0;
    for (i = 0; i < 20 && resp_valid !== 1'b1; i++) @(negedge core_clk);
    chk("resp_valid", 1, resp_valid);
    got = resp_rdata;
  endtask
  task t_reset;
    repeat (12) @(negedge core_clk);
    chk("reset pins", 8'h0F, {addr_latch_strobe, program_store_strobe_n,
      muxed_addr_data_oe, data_read_strobe_n & data_write_strobe_n});
    chk("reset port", 8'hFF, muxed_addr_data_out);
    @(posedge core_clk) rst_n <= 1;
    repeat (6) @(posedge core_clk);
  endtask
  task t_moves;
    bus(0, 8'h3C, 0); chk("fetch", 8'h99, got);
    bus(2, 8'h12, 8'h55); bus(1, 8'h12, 0); chk("read 12", 8'h55, got);
    bus(2, 8'hED, 8'hAA); bus(0, 8'h00, 0); bus(1, 8'hED, 0); chk("read ED", 8'hAA, got);
  endtask
  task t_timers;
    @(posedge core_clk) timer_fast_sel <= 3'h2;
    repeat (8) @(posedge core_clk);
    n0 = 0; n1 = 0; n2 = 0; na = 0;
    repeat (24) begin
      @(negedge core_clk);
      n0 += timer_tick[0]; n1 += timer_tick[1]; n2 += timer_tick[2];
      na += addr_latch_strobe;
    end
    chk("tick0", 2, n0); chk("tick1", 6, n1); chk("tick2", 2, n2);
    chk("ale pulses", 6, na);
  endtask
  task t_fault;
    @(posedge core_clk) external_access_n <= 1;
    repeat (8) @(posedge core_clk);
    req_valid <= 1; req_kind <= 0; n0 = 0; n1 = 0;
    repeat (12) begin
      @(negedge core_clk);
      n0 += access_fault; n1 += !program_store_strobe_n;
    end
    chk("fault seen", 1, n0 > 0); chk("program_store_strobe_n low", 0, n1);
    @(posedge core_clk) req_valid <= 0;
    external_access_n <= 0;
    repeat (8) @(posedge core_clk);
  endtask
  initial begin
    t_reset;
    t_moves;
    t_timers;
    t_fault;
    bus(0, 8'h81, 0); chk("fetch again", 8'h24, got);
    give_verdict;
  end
  initial begin
    #100000;
    err_count++;
    give_verdict;
  end
endmodule
